/* File: cal_serial_access.sv */
// Purpose: two-wire slave giving access to the calibration code registers
// Assumes: scl_in and sda_in are already synchronous to core_clk
// Notes:   open-drain data pin as sda_in / sda_out / sda_oe
//          the pointer never advances; unmapped addresses read as 00h

`timescale 1ns/1ps

module cal_serial_access (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_low,
  input  wire logic       addr_strap_high,
  input  wire logic       boost_supply_rail_ok,
  output logic      [6:0] working_cal_code,
  output logic      [6:0] sink_current_level,
  output logic            prog_busy
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  // one-hot phases of a transaction; start and stop override them all
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_RX   = 7'b0001000,
    ST_RACK = 7'b0010000,
    ST_TX   = 7'b0100000,
    ST_TACK = 7'b1000000
  } bus_state_t;

  bus_state_t state_q;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] ptr_q;
  logic       first_q;
  logic       rd_dir_q;
  logic       oe_q;
  logic [7:0] acc_q;
  logic [6:0] work_q;
  logic [6:0] sink_q;
  logic       dirty_q;
  logic       load_q;
  logic       prog_req_q;
  logic [6:0] nv_rd_data;
  logic       nv_busy;

  // ----------------------------------------------------------------
  // bus event decode
  // ----------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_end;
  logic [6:0] my_addr;
  logic       addr_hit;
  logic       prog_mode;
  logic       prog_ok;
  logic       to_cal;
  logic       to_acc;
  logic [7:0] rd_byte;
  logic       rx_ack;

  // edges and conditions come from the previous sample, so each pin
  // level has to stand for at least two core cycles or it is missed
  assign scl_rise   = scl_in && !scl_q;
  assign scl_fall   = !scl_in && scl_q;
  assign start_cond = scl_in && scl_q && sda_q && !sda_in;
  assign stop_cond  = scl_in && scl_q && !sda_q && sda_in;
  assign byte_end   = scl_fall && (bit_cnt_q == cal_access_pkg::BITS_PER_BYTE);

  // strap order follows the address byte: ... a_low, a_high, r/w
  assign my_addr  = {cal_access_pkg::SLAVE_ADDR_HI,
                     addr_strap_low, addr_strap_high};
  // busy programming hides the device from its own address
  assign addr_hit = (shift_q[7:1] == my_addr) && !nv_busy;

  // pointer decode; only two addresses are mapped
  assign to_cal    = (ptr_q == cal_access_pkg::CAL_REG_ADDR);
  assign to_acc    = (ptr_q == cal_access_pkg::ACC_REG_ADDR);
  assign prog_mode = acc_q[cal_access_pkg::ACC_PROG_BIT];
  // program only on 80h, rail ok, changed data, and no cycle running
  assign prog_ok   = boost_supply_rail_ok && dirty_q
                     && !nv_busy;

  // data bytes are refused only when a program command is refused;
  // the nack is the master's only sign that nothing was committed
  assign rx_ack = first_q || !to_cal || !prog_mode || prog_ok;

  // read-back mux; unmapped pointers read zero
  assign rd_byte = to_cal ? {1'b0, work_q} :
                   to_acc ? acc_q : 8'h00;

  // ----------------------------------------------------------------
  // pin sampling history
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // idle level, so no false edge or start follows reset
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  // start or stop overrides any phase; bits move on scl edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      first_q   <= 1'b0;
      rd_dir_q  <= 1'b0;
    end else if (start_cond) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (stop_cond) begin
      state_q   <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // stray clocks from a transfer to another device are ignored
          bit_cnt_q <= 4'h0;
        end
        ST_ADDR, ST_RX: begin
          // both phases shift alike; they differ only at the byte end
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              rd_dir_q <= shift_q[0];
              first_q  <= 1'b1;
              state_q  <= addr_hit ? ST_AACK : ST_IDLE;
            end else begin
              first_q  <= 1'b0;
              state_q  <= rx_ack ? ST_RACK : ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          // the ninth clock ends; the direction bit picks the next phase
          if (scl_fall) begin
            state_q <= rd_dir_q ? ST_TX : ST_RX;
          end
        end
        ST_RACK: begin
          // further data bytes in the same write go to the same register
          if (scl_fall) begin
            state_q <= ST_RX;
          end
        end
        ST_TX: begin
          // only counts here; the data line logic below drives the bits
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_TACK;
          end
        end
        ST_TACK: begin
          // master ack asks for another byte, nack ends the read
          if (scl_rise) begin
            state_q <= sda_in ? ST_IDLE : ST_TX;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data line drive, open drain, changed only while scl is low
  // ----------------------------------------------------------------
  logic       tx_enter;
  logic [2:0] tx_bit;

  assign tx_enter = scl_fall && ((state_q == ST_AACK && rd_dir_q)
                                 || state_q == ST_TX);
  assign tx_bit   = 3'd7 - bit_cnt_q[2:0];
  assign sda_out  = 1'b0;
  assign sda_oe   = oe_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n || start_cond || stop_cond) begin
      oe_q <= 1'b0;
    end else if (byte_end && state_q != ST_TX) begin
      // low through the whole ninth clock when acking
      oe_q <= (state_q == ST_ADDR) ? addr_hit : rx_ack;
    end else if (byte_end || (scl_fall && state_q == ST_TACK)) begin
      // a read byte ends: hand the line to the master for its ack
      oe_q <= 1'b0;
    end else if (tx_enter) begin
      // next read bit, launched a cycle after the clock falls
      oe_q <= !rd_byte[tx_bit];
    end else if (scl_fall && (state_q == ST_AACK || state_q == ST_RACK)) begin
      // ack clock over on a write; release before the next bit
      oe_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers, pointer and program command
  // ----------------------------------------------------------------
  logic       data_wr;

  assign data_wr = byte_end && state_q == ST_RX && !first_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_q      <= cal_access_pkg::CAL_REG_ADDR;
      acc_q      <= cal_access_pkg::ACC_RESET_VAL;
      dirty_q    <= 1'b0;
      prog_req_q <= 1'b0;
      load_q     <= 1'b1;
      work_q     <= 7'h00;
    end else begin
      prog_req_q <= 1'b0;
      // one-shot recall; every reset is treated as a power-up
      if (load_q) begin
        work_q <= nv_rd_data;
        load_q <= 1'b0;
      end
      // the first data byte of a write is the memory address
      if (byte_end && state_q == ST_RX && first_q) begin
        ptr_q <= shift_q;
      end
      if (data_wr && to_acc) begin
        // reserved bits always hold zero
        acc_q <= shift_q & cal_access_pkg::ACC_PROG_VAL;
      end
      if (data_wr && to_cal && !prog_mode) begin
        work_q  <= shift_q[6:0];
        dirty_q <= 1'b1;
      end
      // the program command also updates the working code
      if (data_wr && to_cal && prog_mode && prog_ok) begin
        work_q     <= shift_q[6:0];
        prog_req_q <= 1'b1;
        dirty_q    <= 1'b0;
      end
    end
  end

  // code zero is the largest current, so current steps are the inverse;
  // registered so the sink never sees a partial code
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sink_q <= 7'h7F;
    end else begin
      sink_q <= ~work_q;
    end
  end

  assign working_cal_code   = work_q;
  assign sink_current_level = sink_q;
  assign prog_busy          = nv_busy;

  // ----------------------------------------------------------------
  // nonvolatile copy
  // ----------------------------------------------------------------
  // the working code is the data source; it holds still while busy
  // because no address is acked until the cycle ends
  nv_cal_store u_store (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .prog_req  (prog_req_q),
    .prog_data (work_q),
    .rd_data_q (nv_rd_data),
    .busy_q    (nv_busy)
  );

endmodule // cal_serial_access

/* File: cal_access_pkg.sv */
// Purpose: shared constants for the calibration-code serial access block
// Assumes: one 250 MHz core clock, bus pins sampled synchronously
// Notes:   offsets, the access register reset value and the program cycle count live here

package cal_access_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CAL_REG_ADDR    = 8'h00;
  localparam logic [7:0] ACC_REG_ADDR    = 8'h02;
  localparam logic [7:0] ACC_RESET_VAL   = 8'h00;
  localparam logic [7:0] ACC_PROG_VAL    = 8'h80;
  localparam int         ACC_PROG_BIT    = 7;
  localparam int         CAL_W           = 7;

  // ----------------------------------------------------------------
  // slave address and byte framing
  // ----------------------------------------------------------------
  localparam logic [4:0] SLAVE_ADDR_HI   = 5'h0A;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ         = 250;
  localparam int         PROG_TIME_US    = 10;
  localparam int         PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam int         PROG_CNT_W      = 12;

  // ----------------------------------------------------------------
  // contents of the nonvolatile copy before any programming
  // ----------------------------------------------------------------
  localparam logic [6:0] NV_FACTORY_VAL  = 7'h40;

endpackage

/* File: nv_cal_store.sv */
// Purpose: nonvolatile copy of the calibration code and its program timer
// Assumes: prog_req is a one-cycle pulse, ignored while busy
// Notes:   storage is not cleared by rst_n, only the timer and pending data are

`timescale 1ns/1ps

module nv_cal_store (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       prog_req,
  input  wire logic [6:0] prog_data,
  output logic      [6:0] rd_data_q,
  output logic            busy_q
);

  // ----------------------------------------------------------------
  // storage and timer
  // ----------------------------------------------------------------
  // power-on content stands in for the cell array; survives rst_n
  logic [6:0]                            mem_q = cal_access_pkg::NV_FACTORY_VAL;
  logic [6:0]                            pend_q;
  logic [cal_access_pkg::PROG_CNT_W-1:0] cnt_q;
  logic                                  done;

  localparam logic [cal_access_pkg::PROG_CNT_W-1:0] LAST_CNT =
    cal_access_pkg::PROG_CNT_W'(cal_access_pkg::PROG_CYCLES - 1);

  assign done = busy_q && (cnt_q == LAST_CNT);

  // cell write happens at the end of the timed cycle
  always_ff @(posedge core_clk) begin
    if (done) begin
      mem_q <= pend_q;
    end
    rd_data_q <= mem_q;
  end

  // timed programming cycle; a request during one is dropped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      pend_q <= 7'h00;
    end else if (prog_req && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= '0;
      pend_q <= prog_data;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q + 1'b1;
    end
  end

endmodule // nv_cal_store

/* File: cal_access_assertions.sv */
// Purpose: port checks on the calibration access block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps

module cal_access_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       addr_strap_low,
  input wire logic       addr_strap_high,
  input wire logic       boost_supply_rail_ok,
  input wire logic [6:0] working_cal_code,
  input wire logic [6:0] sink_current_level,
  input wire logic       prog_busy
);
  localparam int P = cal_access_pkg::PROG_CYCLES;
  int busy_cnt_q;

  // length of the busy phase, cleared while idle
  always_ff @(posedge core_clk) begin
    if (!rst_n || !prog_busy) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence scl_held_high;
    scl_in && $past(scl_in);
  endsequence
  // ack is registered on the same edge as the program request, and busy
  // one edge after it, so the ack stands one sample before busy rises
  sequence ack_launch;
    $past(sda_oe) && sda_oe && boost_supply_rail_ok;
  endsequence

  a_open_drain_low: assert property (sda_out == 1'b0)
    else $error("data pin output not low");
  a_sink_inverse: assert property ($past(rst_n) |->
    sink_current_level == ~$past(working_cal_code))
    else $error("sink level not inverse of code");
  a_stable_scl_high: assert property (scl_held_high |->
    $stable(sda_oe))
    else $error("data pin moved while clock high");
  a_busy_no_ack: assert property (
    prog_busy && $past(prog_busy) |-> !$rose(sda_oe))
    else $error("ack started during programming");
  a_prog_after_ack: assert property (
    $rose(prog_busy) |-> ack_launch)
    else $error("program without ack or rail");
  a_prog_length: assert property (
    $fell(prog_busy) |-> busy_cnt_q >= P - 1 && busy_cnt_q <= P + 1)
    else $error("programming length wrong");
  // the reload one edge after reset may change the code with clock high
  a_code_on_fall: assert property (
    $changed(working_cal_code) && $past(rst_n) && $past(rst_n, 2) |->
    !scl_in)
    else $error("code changed outside clock low");
  a_release_clk_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
endmodule // cal_access_checker

/* File: i2c_master_model.sv */
// Purpose: two-wire bus master driving the calibration block
// Assumes: data line has a pull-up, clock driven push-pull
// Notes:   each clock phase lasts four core cycles
`timescale 1ns/1ps

module i2c_master_model (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // start or repeated start: data falls with clock high
  task automatic start();
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic r);
    sda_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask

  // msb first, ninth clock samples the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = !r;
  endtask

  // last byte is left unacked so a stop can follow
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, r);
  endtask
endmodule // i2c_master_model

/* File: testbench.sv */
// Purpose: self-checking bench for the calibration access block
// Assumes: straps low=1 high=0, bus pull-up on data
// Notes:   register access goes through the master model tasks
`timescale 1ns/1ps

module testbench;
  localparam logic [6:0] SLV = {cal_access_pkg::SLAVE_ADDR_HI, 2'b10};
  localparam logic [7:0] CAL = cal_access_pkg::CAL_REG_ADDR;
  localparam logic [7:0] ACC = cal_access_pkg::ACC_REG_ADDR;
  localparam logic [7:0] NV = {1'b0, cal_access_pkg::NV_FACTORY_VAL};
  logic       core_clk, rst_n, scl, sda_low, sda, rail, oe, ok;
  logic       strap_low, strap_high, sda_out, busy;
  logic [6:0] code, sink;
  logic [7:0] d;
  int         n_mismatch, n_compared, cyc;

  // open drain data line with pull-up
  assign sda = (sda_low || oe) ? 1'b0 : 1'b1;

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  i2c_master_model m (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  cal_serial_access DUT (.core_clk(core_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(oe),
    .addr_strap_low(strap_low), .addr_strap_high(strap_high),
    .boost_supply_rail_ok(rail), .working_cal_code(code),
    .sink_current_level(sink), .prog_busy(busy));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ma, input logic [7:0] v,
                    output logic a);
    logic a0, a1, a2;
    m.start();
    m.wbyte({SLV, 1'b0}, a0);
    m.wbyte(ma, a1);
    m.wbyte(v, a2);
    m.stop();
    a = a0 & a1 & a2;
  endtask

  // dummy write sets the pointer, then one unacked read byte
  task automatic rd(input logic [7:0] ma, output logic [7:0] v);
    logic a;
    m.start();
    m.wbyte({SLV, 1'b0}, a);
    m.wbyte(ma, a);
    m.start();
    m.wbyte({SLV, 1'b1}, a);
    m.rbyte(1'b1, v);
    m.stop();
  endtask

  task automatic poll(input logic [6:0] sa, output logic a);
    m.start();
    m.wbyte({sa, 1'b0}, a);
    m.stop();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    rst_n = 1'b0;
    rail = 1'b0;
    strap_low = 1'b1;
    strap_high = 1'b0;
    do_reset();
    check({1'b0, code}, NV);
    check({1'b0, sink}, {1'b0, ~NV[6:0]});
    rd(CAL, d);
    check(d, NV);
    rd(ACC, d);
    check(d, cal_access_pkg::ACC_RESET_VAL);
    rd(8'h05, d);
    check(d, 8'h00);
    poll(SLV ^ 7'h06, ok);
    check({7'h00, ok}, 8'h00);
    wr(CAL, 8'hB3, ok);
    check({7'h00, ok}, 8'h01);
    check({1'b0, code}, 8'h33);
    check({1'b0, sink}, 8'h4C);
    check({7'h00, busy}, 8'h00);
    wr(ACC, cal_access_pkg::ACC_PROG_VAL, ok);
    check({7'h00, ok}, 8'h01);
    rd(ACC, d);
    check(d, 8'h80);
    wr(CAL, 8'h25, ok);
    check({7'h00, ok}, 8'h00);
    check({1'b0, code}, 8'h33);
    check({7'h00, busy}, 8'h00);
    rail <= 1'b1;
    wr(CAL, 8'h25, ok);
    check({7'h00, ok}, 8'h01);
    check({7'h00, busy}, 8'h01);
    poll(SLV, ok);
    check({7'h00, ok}, 8'h00);
    for (int i = 0; i < 40 && !ok; i++) begin
      poll(SLV, ok);
    end
    check({7'h00, ok}, 8'h01);
    wr(CAL, 8'h25, ok);
    check({7'h00, ok}, 8'h00);
    do_reset();
    check({1'b0, code}, 8'h25);
    rd(ACC, d);
    check(d, 8'h00);
    complete_run();
  end
endmodule // testbench

bind cal_serial_access cal_access_checker chk (.core_clk(core_clk),
  .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
  .addr_strap_high(addr_strap_high),
  .boost_supply_rail_ok(boost_supply_rail_ok),
  .working_cal_code(working_cal_code),
  .sink_current_level(sink_current_level), .prog_busy(prog_busy));
